// ===== rtl/fap_pkg.sv
// Shared constants, types and timing for the flash program/erase host controller
package fap_pkg;
	localparam int CLK_MHZ = 25;
	localparam int ADDR_W = 17;
	localparam int T_VPP_RAMP_NS = 500;
	localparam int T_ADDR_SETUP_NS = 40;
	localparam int T_STROBE_NS = 120;
	localparam int T_HOLD_NS = 40;

	// Least times round up to whole cycles, never below one
	function automatic logic [7:0] fap_ns2cyc(input int ns);
		int v;
		v = (ns * CLK_MHZ + 999) / 1000;
		if (v < 1) begin
			v = 1;
		end
		return v[7:0];
	endfunction : fap_ns2cyc

	localparam logic [7:0] RAMP_CYC = fap_ns2cyc(T_VPP_RAMP_NS);
	localparam logic [7:0] SETUP_CYC = fap_ns2cyc(T_ADDR_SETUP_NS);
	localparam logic [7:0] STROBE_CYC = fap_ns2cyc(T_STROBE_NS);
	localparam logic [7:0] HOLD_CYC = fap_ns2cyc(T_HOLD_NS);
	localparam logic [7:0] CNT_ONE = 8'h01;

	localparam logic [7:0] CMD_ERASE = 8'h30;
	localparam logic [7:0] CMD_PROG = 8'h10;
	localparam logic [7:0] CMD_RESET = 8'hff;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	localparam int COMPLETION_POLARITY_BIT = 7;
	localparam int ALTERNATING_STATUS_BIT = 6;
	localparam int TIME_LIMIT_FAIL_BIT = 5;

	localparam logic [11:0] A_CTRL = 12'h000;
	localparam logic [11:0] A_ADDR = 12'h004;
	localparam logic [11:0] A_WDATA = 12'h008;
	localparam logic [11:0] A_STATUS = 12'h00c;
	localparam logic [11:0] A_RDATA = 12'h010;

	localparam int F_OP_MSB = 2;
	localparam int F_TOGGLE = 4;
	localparam int F_VPP = 8;
	localparam int F_BUSY = 0;
	localparam int F_DONE = 1;
	localparam int F_FAIL = 2;
	localparam int F_VERR = 3;
	localparam int F_VPP_OK = 4;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PROG = 3'h1,
		OP_ERASE = 3'h2,
		OP_READ = 3'h3,
		OP_RESET = 3'h4
	} fap_op_t;

	typedef struct packed {
		logic wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} fap_cyc_req_t;

	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [ADDR_W-1:0] addr;
		logic [7:0] dq_out;
		logic dq_oe;
	} fap_pins_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} fap_apb_req_t;
endpackage : fap_pkg

// ===== rtl/fap_cycle.sv
// One write or read cycle on the flash pins, timed in clock cycles
`timescale 1ns/1ps
`default_nettype none
module fap_cycle import fap_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire fap_cyc_req_t req,
	input wire logic [7:0] dq_in,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output fap_pins_t pins
);
	typedef enum logic [3:0] {
		C_IDLE = 4'b0001,
		C_SETUP = 4'b0010,
		C_STROBE = 4'b0100,
		C_HOLD = 4'b1000
	} fap_cst_t;

	typedef struct packed {
		fap_cst_t state;
		logic [7:0] cnt;
		logic wr;
		fap_pins_t pins;
		logic [7:0] rdata;
		logic done;
	} fap_cyc_st_t;

	fap_cyc_st_t st;
	fap_cyc_st_t next_st;

	// Chip select falls first and rises last, so the write strobe edges decide latching
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.state)
			C_IDLE: begin
				if (start) begin
					next_st.wr = req.wr;
					next_st.pins.ce_n = 1'b0;
					next_st.pins.addr = req.addr;
					next_st.pins.dq_out = req.data;
					next_st.pins.dq_oe = req.wr;
					next_st.cnt = SETUP_CYC;
					next_st.state = C_SETUP;
				end
			end
			C_SETUP: begin
				if (st.cnt > CNT_ONE) begin
					next_st.cnt = st.cnt - CNT_ONE;
				end else begin
					next_st.pins.we_n = !st.wr;
					next_st.pins.oe_n = st.wr;
					next_st.cnt = STROBE_CYC;
					next_st.state = C_STROBE;
				end
			end
			C_STROBE: begin
				if (st.cnt > CNT_ONE) begin
					next_st.cnt = st.cnt - CNT_ONE;
				end else begin
					// Sampled while the output gate is still low
					if (!st.wr) begin
						next_st.rdata = dq_in;
					end
					next_st.pins.we_n = 1'b1;
					next_st.pins.oe_n = 1'b1;
					next_st.cnt = HOLD_CYC;
					next_st.state = C_HOLD;
				end
			end
			C_HOLD: begin
				if (st.cnt > CNT_ONE) begin
					next_st.cnt = st.cnt - CNT_ONE;
				end else begin
					next_st.pins.ce_n = 1'b1;
					next_st.pins.dq_oe = 1'b0;
					next_st.done = 1'b1;
					next_st.state = C_IDLE;
				end
			end
			default: begin
				next_st.state = C_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{state: C_IDLE, cnt: 8'h00, wr: 1'b0,
				pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq_out: 8'h00, dq_oe: 1'b0},
				rdata: 8'h00, done: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign busy = (st.state != C_IDLE);
	assign done = st.done;
	assign rdata = st.rdata;
	assign pins = st.pins;
endmodule : fap_cycle
`default_nettype wire

// ===== rtl/fap_host.sv
// Host controller that programs and erases a parallel flash through its pins
`timescale 1ns/1ps
`default_nettype none
module fap_host import fap_pkg::*; #(
	parameter int ARRAY_BYTES = 131072
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire fap_apb_req_t apb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] flash_dq_in,
	output fap_pins_t flash_pins,
	output logic vpp_en
);
	localparam logic [ADDR_W-1:0] VLAST = ADDR_W'(ARRAY_BYTES - 1);
	localparam logic [ADDR_W-1:0] ADDR_ONE = 17'h00001;

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_RAMP = 7'b0000010,
		S_SETUP = 7'b0000100,
		S_SECOND = 7'b0001000,
		S_POLL = 7'b0010000,
		S_VERIFY = 7'b0100000,
		S_READ = 7'b1000000
	} fap_hst_t;

	typedef struct packed {
		fap_hst_t state;
		fap_op_t op;
		logic toggle_mode;
		logic vpp_en;
		logic [7:0] vpp_cnt;
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic [ADDR_W-1:0] vaddr;
		logic inflight;
		logic recheck;
		logic prev6;
		logic have_prev;
		logic done;
		logic fail;
		logic verify_err;
		logic [7:0] rdata;
		logic [31:0] prdata;
		logic pslverr;
	} fap_host_st_t;

	fap_host_st_t st;
	fap_host_st_t next_st;
	fap_cyc_req_t creq;
	logic cyc_start;
	logic cyc_busy;
	logic cyc_done;
	logic [7:0] cyc_rdata;
	logic vpp_ok;
	logic poll_match;

	function automatic logic fap_mapped(input logic [11:0] a);
		if (a == A_CTRL) begin
			return 1'b1;
		end else if (a == A_ADDR || a == A_WDATA) begin
			return 1'b1;
		end else if (a == A_STATUS || a == A_RDATA) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction : fap_mapped

	fap_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.start(cyc_start),
		.req(creq),
		.dq_in(flash_dq_in),
		.busy(cyc_busy),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.pins(flash_pins)
	);

	// The supply counts as settled only after its ramp time has run since enable
	assign vpp_ok = st.vpp_en && (st.vpp_cnt == RAMP_CYC);
	// Erase completes on a one in bit 7, programming on the written bit coming back
	assign poll_match = (st.op == OP_ERASE) ? cyc_rdata[COMPLETION_POLARITY_BIT] :
		(cyc_rdata[COMPLETION_POLARITY_BIT] == st.wdata[COMPLETION_POLARITY_BIT]);

	always_comb begin
		next_st = st;
		cyc_start = 1'b0;
		creq = '{wr: 1'b0, addr: st.addr, data: 8'h00};
		if (!st.vpp_en) begin
			next_st.vpp_cnt = 8'h00;
		end else if (st.vpp_cnt != RAMP_CYC) begin
			next_st.vpp_cnt = st.vpp_cnt + CNT_ONE;
		end
		if (apb.psel && !apb.penable) begin
			next_st.pslverr = !fap_mapped(apb.paddr);
			next_st.prdata = 32'h0000_0000;
			if (apb.paddr == A_CTRL) begin
				next_st.prdata[F_OP_MSB:0] = st.op;
				next_st.prdata[F_TOGGLE] = st.toggle_mode;
				next_st.prdata[F_VPP] = st.vpp_en;
			end else if (apb.paddr == A_ADDR) begin
				next_st.prdata[ADDR_W-1:0] = st.addr;
			end else if (apb.paddr == A_WDATA) begin
				next_st.prdata[7:0] = st.wdata;
			end else if (apb.paddr == A_STATUS) begin
				next_st.prdata[F_BUSY] = (st.state != S_IDLE);
				next_st.prdata[F_DONE] = st.done;
				next_st.prdata[F_FAIL] = st.fail;
				next_st.prdata[F_VERR] = st.verify_err;
				next_st.prdata[F_VPP_OK] = vpp_ok;
			end else if (apb.paddr == A_RDATA) begin
				next_st.prdata[7:0] = st.rdata;
			end
		end
		// Orders and settings are only taken while idle; a running sequence is never disturbed
		if (apb.psel && apb.penable && apb.pwrite && st.state == S_IDLE) begin
			if (apb.paddr == A_CTRL) begin
				next_st.toggle_mode = apb.pwdata[F_TOGGLE];
				next_st.vpp_en = apb.pwdata[F_VPP];
				next_st.op = fap_op_t'(apb.pwdata[F_OP_MSB:0]);
				next_st.done = 1'b0;
				next_st.fail = 1'b0;
				next_st.verify_err = 1'b0;
				case (apb.pwdata[F_OP_MSB:0])
					OP_PROG, OP_ERASE: begin
						next_st.vpp_en = 1'b1;
						next_st.state = S_RAMP;
					end
					OP_READ: begin
						next_st.state = S_READ;
					end
					OP_RESET: begin
						next_st.state = S_SETUP;
					end
					default: begin
						next_st.op = st.op;
						next_st.done = st.done;
						next_st.fail = st.fail;
						next_st.verify_err = st.verify_err;
					end
				endcase
			end else if (apb.paddr == A_ADDR) begin
				next_st.addr = apb.pwdata[ADDR_W-1:0];
			end else if (apb.paddr == A_WDATA) begin
				next_st.wdata = apb.pwdata[7:0];
			end
		end
		if (cyc_done) begin
			next_st.inflight = 1'b0;
		end
		case (st.state)
			S_IDLE: begin
			end
			S_RAMP: begin
				if (vpp_ok) begin
					next_st.state = S_SETUP;
				end
			end
			S_SETUP: begin
				creq.wr = 1'b1;
				if (st.op == OP_ERASE) begin
					creq.data = CMD_ERASE;
				end else if (st.op == OP_PROG) begin
					creq.data = CMD_PROG;
				end else begin
					creq.data = CMD_RESET;
				end
				if (cyc_done) begin
					next_st.state = S_SECOND;
				end
			end
			S_SECOND: begin
				creq.wr = 1'b1;
				if (st.op == OP_ERASE) begin
					creq.data = CMD_ERASE;
				end else if (st.op == OP_PROG) begin
					creq.data = st.wdata;
				end else begin
					creq.data = CMD_RESET;
				end
				if (cyc_done) begin
					next_st.recheck = 1'b0;
					next_st.have_prev = 1'b0;
					if (st.op == OP_RESET) begin
						next_st.done = 1'b1;
						next_st.state = S_IDLE;
					end else begin
						next_st.state = S_POLL;
					end
				end
			end
			S_POLL: begin
				if (cyc_done) begin
					next_st.rdata = cyc_rdata;
					next_st.prev6 = cyc_rdata[ALTERNATING_STATUS_BIT];
					next_st.have_prev = 1'b1;
					if (st.toggle_mode && !st.have_prev) begin
						next_st.state = S_POLL;
					end else if (st.toggle_mode ?
						(cyc_rdata[ALTERNATING_STATUS_BIT] == st.prev6) : poll_match) begin
						next_st.vaddr = '0;
						if (st.op == OP_ERASE) begin
							next_st.state = S_VERIFY;
						end else begin
							next_st.done = 1'b1;
							next_st.state = S_IDLE;
						end
					end else if (st.recheck) begin
						// Still busy on the read after the limit bit was seen: a real failure
						next_st.fail = 1'b1;
						next_st.done = 1'b1;
						next_st.state = S_IDLE;
					end else if (cyc_rdata[TIME_LIMIT_FAIL_BIT]) begin
						next_st.recheck = 1'b1;
					end
				end
			end
			S_VERIFY: begin
				creq.addr = st.vaddr;
				if (cyc_done) begin
					next_st.rdata = cyc_rdata;
					if (cyc_rdata != ERASED_BYTE) begin
						next_st.verify_err = 1'b1;
						next_st.fail = 1'b1;
						next_st.done = 1'b1;
						next_st.state = S_IDLE;
					end else if (st.vaddr == VLAST) begin
						next_st.done = 1'b1;
						next_st.state = S_IDLE;
					end else begin
						next_st.vaddr = st.vaddr + ADDR_ONE;
					end
				end
			end
			S_READ: begin
				if (cyc_done) begin
					next_st.rdata = cyc_rdata;
					next_st.done = 1'b1;
					next_st.state = S_IDLE;
				end
			end
			default: begin
				next_st.state = S_IDLE;
			end
		endcase
		// One pin cycle at a time; the completion pulse clears the flag
		if (st.state != S_IDLE && st.state != S_RAMP && !st.inflight && !cyc_busy) begin
			cyc_start = 1'b1;
			next_st.inflight = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '{state: S_IDLE, op: OP_NONE, toggle_mode: 1'b0, vpp_en: 1'b0, vpp_cnt: 8'h00,
				addr: '0, wdata: 8'h00, vaddr: '0, inflight: 1'b0, recheck: 1'b0, prev6: 1'b0,
				have_prev: 1'b0, done: 1'b0, fail: 1'b0, verify_err: 1'b0, rdata: 8'h00,
				prdata: 32'h0000_0000, pslverr: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign prdata = st.prdata;
	assign pready = apb.psel && apb.penable;
	assign pslverr = apb.psel && apb.penable && st.pslverr;
	assign vpp_en = st.vpp_en;

	property p_erase_setup;
		@(posedge pclk) disable iff (!presetn)
		cyc_start && st.state == S_SETUP && st.op == OP_ERASE |-> creq.wr && creq.data == CMD_ERASE;
	endproperty
	a_erase_setup: assert property (p_erase_setup) else $error("erase setup not 30h");

	property p_erase_go;
		@(posedge pclk) disable iff (!presetn)
		cyc_done && st.state == S_SETUP && st.op == OP_ERASE |=>
			st.state == S_SECOND ##1 (creq.wr && creq.data == CMD_ERASE);
	endproperty
	a_erase_go: assert property (p_erase_go) else $error("second erase write not 30h");

	property p_vpp_first;
		@(posedge pclk) disable iff (!presetn)
		cyc_start && creq.wr && st.op != OP_RESET |-> vpp_ok && $past(st.vpp_en, 2);
	endproperty
	a_vpp_first: assert property (p_vpp_first) else $error("write before supply ramp");

	property p_prog_setup;
		@(posedge pclk) disable iff (!presetn)
		cyc_start && st.state == S_SETUP && st.op == OP_PROG |-> creq.wr && creq.data == CMD_PROG;
	endproperty
	a_prog_setup: assert property (p_prog_setup) else $error("program setup not 10h");

	property p_prog_data;
		@(posedge pclk) disable iff (!presetn)
		cyc_start && st.state == S_SECOND && st.op == OP_PROG |->
			creq.addr == st.addr && creq.data == st.wdata ##1 flash_pins.ce_n == 1'b0;
	endproperty
	a_prog_data: assert property (p_prog_data) else $error("program cycle wrong");

	property p_recheck_data;
		@(posedge pclk) disable iff (!presetn)
		cyc_done && st.state == S_POLL && !st.toggle_mode && !st.recheck && !poll_match &&
			cyc_rdata[TIME_LIMIT_FAIL_BIT] |=> st.recheck && !st.fail && st.state == S_POLL;
	endproperty
	a_recheck_data: assert property (p_recheck_data) else $error("no bit 7 recheck");

	property p_recheck_tog;
		@(posedge pclk) disable iff (!presetn)
		cyc_done && st.state == S_POLL && st.toggle_mode && st.have_prev && !st.recheck &&
			cyc_rdata[ALTERNATING_STATUS_BIT] != st.prev6 && cyc_rdata[TIME_LIMIT_FAIL_BIT]
			|=> st.recheck && !st.fail ##1 st.state == S_POLL;
	endproperty
	a_recheck_tog: assert property (p_recheck_tog) else $error("no bit 6 recheck");

	property p_reset_twice;
		@(posedge pclk) disable iff (!presetn)
		cyc_done && st.state == S_SETUP && st.op == OP_RESET |=>
			st.state == S_SECOND && cyc_start && creq.wr && creq.data == CMD_RESET;
	endproperty
	a_reset_twice: assert property (p_reset_twice) else $error("reset not written twice");
endmodule : fap_host
`default_nettype wire

// ===== tb/fap_flash_model.sv
// Behavioural byte-wide flash whose program and chip erase finish after a set count of status reads
`timescale 1ns/1ps
`default_nettype none
module fap_flash_model #(
	parameter int BYTES = 4,
	parameter int BUSY_READS = 3
) (
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [16:0] addr,
	input wire logic [7:0] dq_in,
	input wire logic vpp,
	input wire logic fail_en,
	output logic [7:0] dq_out,
	output logic dq_drv
);
	// States: 0 read, 1 erase staged, 2 program staged, 3 programming, 4 erasing
	logic [7:0] mem [BYTES];
	logic [16:0] la = '0;
	logic [7:0] pd = 8'h00;
	logic tog = 1'b0;
	int st = 0;
	int cnt = 0;
	initial begin
		foreach (mem[i]) mem[i] = 8'hff;
		dq_out = 8'h00;
	end
	assign dq_drv = !ce_n && !oe_n;
	always @(negedge we_n or negedge ce_n) begin
		if (!we_n && !ce_n) la = addr;
	end
	// Exactly one strobe high means this is the earlier rise
	always @(posedge we_n or posedge ce_n) begin
		if (oe_n && (we_n != ce_n) && vpp) begin
			case (st)
				0: st = (dq_in == 8'h30) ? 1 : (dq_in == 8'h10 || dq_in == 8'h50) ? 2 : 0;
				1: begin
					st = (dq_in == 8'h30) ? 4 : 0;
					cnt = BUSY_READS;
					if (st == 4) foreach (mem[i]) mem[i] = 8'h00;
				end
				2: begin
					pd = dq_in;
					st = 3;
					cnt = BUSY_READS;
				end
				// A reset code aborts a running operation and leaves the array alone
				default: if (dq_in == 8'hff || dq_in == 8'h00) st = 0;
			endcase
		end
	end
	always @(negedge oe_n or negedge ce_n) begin
		if (!oe_n && !ce_n) begin
			tog = ~tog;
			if (st >= 3 && cnt > 0) cnt--;
			if (st >= 3 && cnt == 0 && !fail_en) begin
				if (st == 3) mem[la % BYTES] &= pd;
				else foreach (mem[i]) mem[i] = 8'hff;
				st = 0;
			end
			if (st == 3) dq_out = {~pd[7], tog, fail_en && cnt == 0, 5'h00};
			else if (st == 4) dq_out = {1'b0, tog, fail_en && cnt == 0, 5'h00};
			else if (st != 0) dq_out = {1'b0, tog, 6'h00};
			else dq_out = mem[addr % BYTES];
		end
	end
endmodule : fap_flash_model
`default_nettype wire

// ===== tb/fap_host_tb.sv
// Self-checking bench for the flash program and erase host controller
`timescale 1ns/1ps
`default_nettype none
module fap_host_tb import fap_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	fap_apb_req_t apb = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic vpp_en;
	fap_pins_t pins;
	logic [7:0] mdq;
	logic mdrv;
	logic [7:0] idle_pat = 8'h5a;
	logic [7:0] dq_bus;
	logic fail_en = 1'b0;
	int error_cnt = 0;
	int comparisons = 0;
	logic [7:0] ref_mem [4];
	logic [31:0] rd_v;
	logic err_v;

	always #20 pclk = ~pclk;
	// A released bus shows a changing pattern so stale data cannot pass
	always @(posedge pclk) idle_pat <= ~idle_pat;
	assign dq_bus = pins.dq_oe ? pins.dq_out : (mdrv ? mdq : idle_pat);

	fap_host #(.ARRAY_BYTES(4)) dut (.pclk(pclk), .presetn(presetn), .apb(apb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_dq_in(dq_bus),
		.flash_pins(pins), .vpp_en(vpp_en));
	fap_flash_model #(.BYTES(4), .BUSY_READS(3)) flash (.ce_n(pins.ce_n), .we_n(pins.we_n),
		.oe_n(pins.oe_n), .addr(pins.addr), .dq_in(dq_bus), .vpp(vpp_en), .fail_en(fail_en),
		.dq_out(mdq), .dq_drv(mdrv));

	task automatic end_sim;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_sim

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic apb_xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		apb.psel <= 1'b1;
		apb.penable <= 1'b0;
		apb.pwrite <= w;
		apb.paddr <= a;
		apb.pwdata <= d;
		@(posedge pclk);
		apb.penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_v = prdata;
		err_v = pslverr;
		apb.psel <= 1'b0;
		apb.penable <= 1'b0;
		@(posedge pclk);
	endtask : apb_xfer

	task automatic run_op(input logic [31:0] ctl);
		int n;
		n = 0;
		apb_xfer(1'b1, A_CTRL, ctl);
		rd_v = 32'h1;
		while (rd_v[F_BUSY] !== 1'b0 && n < 5000) begin
			apb_xfer(1'b0, A_STATUS, 32'h0);
			n++;
		end
		if (n >= 5000) check("busy wait", 32'h0, 32'h1);
	endtask : run_op

	task automatic read_at(input logic [1:0] a);
		apb_xfer(1'b1, A_ADDR, {30'h0, a});
		run_op(32'h3);
		apb_xfer(1'b0, A_RDATA, 32'h0);
		check("array byte", {24'h0, ref_mem[a]}, rd_v);
	endtask : read_at

	initial begin
		repeat (60000) @(posedge pclk);
		error_cnt++;
		end_sim();
	end

	initial begin
		logic [1:0] a;
		logic [7:0] d;
		void'($urandom(98159));
		foreach (ref_mem[i]) ref_mem[i] = 8'hff;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb_xfer(1'b0, A_STATUS, 32'h0);
		check("status after reset", 32'h0, rd_v);
		check("supply after reset", 32'h0, {31'h0, vpp_en});
		apb_xfer(1'b1, 12'h020, 32'hffff_ffff);
		check("unmapped write error", 32'h1, {31'h0, err_v});
		apb_xfer(1'b0, 12'h020, 32'h0);
		check("unmapped read data", 32'h0, rd_v);
		// Byte programs in both poll modes; bits only fall, so repeats AND together
		for (int i = 0; i < 8; i++) begin
			a = 2'($urandom % 4);
			// Only clear bits: a one over a zero never verifies, so bit 7 polling would hang
			d = 8'($urandom) & ref_mem[a];
			apb_xfer(1'b1, A_ADDR, {30'h0, a});
			apb_xfer(1'b1, A_WDATA, {24'h0, d});
			run_op((i % 2) ? 32'h111 : 32'h101);
			ref_mem[a] &= d;
			check("program status", 32'h2, rd_v & 32'hf);
			check("supply held", 32'h1, {31'h0, vpp_en});
			read_at(a);
		end
		for (int m = 0; m < 2; m++) begin
			run_op(m ? 32'h112 : 32'h102);
			check("erase status", 32'h2, rd_v & 32'hf);
			foreach (ref_mem[i]) ref_mem[i] = 8'hff;
			for (int j = 0; j < 4; j++) read_at(2'(j));
		end
		// Device never completes: host must give up and report, ignoring writes meanwhile
		// Both poll modes; the reset keeps the supply on, else the abort writes are ignored
		for (int m = 0; m < 2; m++) begin
			fail_en <= 1'b1;
			apb_xfer(1'b1, A_ADDR, 32'h1);
			apb_xfer(1'b1, A_WDATA, 32'h0);
			apb_xfer(1'b1, A_CTRL, m ? 32'h111 : 32'h101);
			apb_xfer(1'b1, A_ADDR, 32'h3);
			run_op(32'h101);
			check("fail flag", 32'h1, {31'h0, rd_v[F_FAIL]});
			apb_xfer(1'b0, A_ADDR, 32'h0);
			check("address kept while busy", 32'h1, rd_v);
			fail_en <= 1'b0;
			run_op(32'h104);
			check("reset status", 32'h2, rd_v & 32'hf);
			read_at(2'h1);
		end
		end_sim();
	end
endmodule : fap_host_tb
`default_nettype wire
